/* File: core/sysctl_regs.sv */
// System control register bank with oscillator and pin-function selection.
// Assumes an APB master, system-clock-synchronous inputs and static option straps.
`timescale 1ns/1ps
module sysctl_regs (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [sysctl_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire sysctl_pkg::osc_cfg_t osc_cfg_i,
    input wire sysctl_pkg::rc_freq_t rc_freq_cfg_i,
    input wire logic wdt_option_on_i,
    input wire logic sleep_req_i,
    input wire logic [7:0] port_a_in_i,
    input wire logic [1:0] wdt_src_sel_i,
    input wire logic [1:0] tb_src_sel_i,
    output logic divider_true_en_o,
    output logic divider_comp_en_o,
    output logic divider_pin_true_gpio_o,
    output logic divider_pin_comp_gpio_o,
    output logic slow_crystal_low_power_o,
    output logic fast_rc_run_o,
    output logic slow_crystal_run_o,
    output logic sys_clk_from_slow_o,
    output logic sys_clk_gate_fast_o,
    output logic sys_clk_gate_slow_o,
    output logic sys_clk_run_o,
    output logic timers_run_o,
    output logic [1:0] fast_rc_freq_o,
    output logic osc_pin_one_gpio_o,
    output logic osc_pin_two_gpio_o,
    output logic config_error_o,
    output logic ext_irq_rise_en_o,
    output logic ext_irq_fall_en_o,
    output logic [3:0] timebase_exp_o,
    output logic watchdog_en_o,
    output logic [1:0] wdt_clk_sel_o,
    output logic [1:0] tb_clk_sel_o,
    output logic wake_o,
    output logic [7:0] port_a_pullhigh_o,
    output logic [7:0] port_b_pullhigh_o,
    output logic [7:0] port_c_pullhigh_o,
    output logic [7:0] port_d_pullhigh_o,
    output logic [3:0] lcd_common_line_o
);
    import sysctl_pkg::*;

    logic [3:0] system_control_a_r;
    logic [7:0] system_control_b_r;
    logic [7:0] port_a_wake_select_r;
    logic [7:0] port_a_pullhigh_select_r;
    logic [7:0] port_b_pullhigh_select_r;
    logic [7:0] port_c_pullhigh_select_r;
    logic [7:0] port_d_pullhigh_select_r;
    logic [3:0] lcd_common_line_control_r;
    logic [7:0] port_a_prev_r;
    logic asleep_r;
    clk_sw_t sw_state_r;
    clk_sw_t sw_state_nxt;
    logic [3:0] sw_cnt_r;

    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [7:0] rd_byte;
    logic slow_pair;
    logic want_slow;
    logic [1:0] div_field;

    // Register address decode, shared by mapping check and read mux.
    function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        is_addr = (a == ofs);
    endfunction

    // The slave answers in the first access cycle, so pready is held high.
    assign pready_o = 1'b1;
    assign wr_acc = psel_i & penable_i & pwrite_i & clk_en_i & mapped;
    assign rd_acc = psel_i & penable_i & ~pwrite_i;

    always_comb begin
        mapped = is_addr(paddr_i, CTRL_A_OFS) | is_addr(paddr_i, CTRL_B_OFS) |
                 is_addr(paddr_i, WAKE_OFS) | is_addr(paddr_i, PU_A_OFS) |
                 is_addr(paddr_i, PU_B_OFS) | is_addr(paddr_i, PU_C_OFS) |
                 is_addr(paddr_i, PU_D_OFS) | is_addr(paddr_i, COM_OFS) |
                 is_addr(paddr_i, STATUS_OFS);
    end

    assign pslverr_o = psel_i & penable_i & ~mapped;

    always_comb begin
        rd_byte = 8'h00;
        if (is_addr(paddr_i, CTRL_A_OFS)) begin
            rd_byte = {4'h0, system_control_a_r};
        end else if (is_addr(paddr_i, CTRL_B_OFS)) begin
            rd_byte = system_control_b_r;
        end else if (is_addr(paddr_i, WAKE_OFS)) begin
            rd_byte = port_a_wake_select_r;
        end else if (is_addr(paddr_i, PU_A_OFS)) begin
            rd_byte = port_a_pullhigh_select_r;
        end else if (is_addr(paddr_i, PU_B_OFS)) begin
            rd_byte = port_b_pullhigh_select_r;
        end else if (is_addr(paddr_i, PU_C_OFS)) begin
            rd_byte = port_c_pullhigh_select_r;
        end else if (is_addr(paddr_i, PU_D_OFS)) begin
            rd_byte = port_d_pullhigh_select_r;
        end else if (is_addr(paddr_i, COM_OFS)) begin
            rd_byte = {4'h0, lcd_common_line_control_r};
        end else if (is_addr(paddr_i, STATUS_OFS)) begin
            rd_byte = {3'h0, config_error_o, sw_state_r};
        end
    end

    // Read data is loaded at the setup edge and held through the access cycle.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (psel_i & ~penable_i & ~pwrite_i) begin
                prdata_o <= {24'h00_0000, rd_byte};
            end else if (!rd_acc) begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            system_control_a_r <= CTRL_A_RST[3:0];
            system_control_b_r <= CTRL_B_RST;
        end else if (wr_acc) begin
            if (is_addr(paddr_i, CTRL_A_OFS)) begin
                system_control_a_r <= pwdata_i[3:0] & CTRL_A_MASK;
            end
            if (is_addr(paddr_i, CTRL_B_OFS)) begin
                system_control_b_r <= pwdata_i[7:0];
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_a_wake_select_r <= PORT_SEL_RST;
            port_a_pullhigh_select_r <= PORT_SEL_RST;
            port_b_pullhigh_select_r <= PORT_SEL_RST;
            port_c_pullhigh_select_r <= PORT_SEL_RST;
            port_d_pullhigh_select_r <= PORT_SEL_RST;
            lcd_common_line_control_r <= COM_RST;
        end else if (wr_acc) begin
            if (is_addr(paddr_i, WAKE_OFS)) begin
                port_a_wake_select_r <= pwdata_i[7:0];
            end
            if (is_addr(paddr_i, PU_A_OFS)) begin
                port_a_pullhigh_select_r <= pwdata_i[7:0];
            end
            if (is_addr(paddr_i, PU_B_OFS)) begin
                port_b_pullhigh_select_r <= pwdata_i[7:0];
            end
            if (is_addr(paddr_i, PU_C_OFS)) begin
                port_c_pullhigh_select_r <= pwdata_i[7:0];
            end
            if (is_addr(paddr_i, PU_D_OFS)) begin
                port_d_pullhigh_select_r <= pwdata_i[7:0];
            end
            if (is_addr(paddr_i, COM_OFS)) begin
                lcd_common_line_control_r <= pwdata_i[3:0];
            end
        end
    end

    // Divider enables are decoded from the write data so they change together with
    // the register; the reserved code behaves as disabled.
    assign div_field = pwdata_i[DIVEN_LSB+1:DIVEN_LSB];
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            divider_true_en_o <= 1'b0;
            divider_comp_en_o <= 1'b0;
        end else if (wr_acc & is_addr(paddr_i, CTRL_A_OFS)) begin
            divider_true_en_o <= (div_field == DIV_TRUE) | (div_field == DIV_BOTH);
            divider_comp_en_o <= (div_field == DIV_BOTH);
        end
    end
    assign divider_pin_true_gpio_o = ~divider_true_en_o;
    assign divider_pin_comp_gpio_o = ~divider_comp_en_o;

    assign slow_crystal_low_power_o = system_control_a_r[LOWPWR_BIT];

    // Only the fast internal RC may pair with the slow crystal.
    assign slow_pair = (osc_cfg_i == OSC_INT_RC_SLOW_XTAL);
    assign want_slow = slow_pair & system_control_a_r[CLKMODE_BIT];
    assign config_error_o = 1'b0;

    // Break-before-make switch: both gates close, a settle interval passes, then the
    // new source opens, so the system clock never sees a runt pulse.
    always_comb begin
        sw_state_nxt = sw_state_r;
        unique case (sw_state_r)
            CS_FAST: begin
                if (want_slow) begin
                    sw_state_nxt = CS_TO_SLOW;
                end
            end
            CS_TO_SLOW: begin
                if (sw_cnt_r == SW_SETTLE_CYC) begin
                    sw_state_nxt = CS_SLOW;
                end
            end
            CS_SLOW: begin
                if (!want_slow) begin
                    sw_state_nxt = CS_TO_FAST;
                end
            end
            CS_TO_FAST: begin
                if (sw_cnt_r == SW_SETTLE_CYC) begin
                    sw_state_nxt = CS_FAST;
                end
            end
            default: sw_state_nxt = CS_FAST;
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sw_state_r <= CS_FAST;
            sw_cnt_r <= 4'h0;
        end else if (clk_en_i) begin
            sw_state_r <= sw_state_nxt;
            if (sw_state_nxt != sw_state_r) begin
                sw_cnt_r <= 4'h0;
            end else if (sw_cnt_r != SW_SETTLE_CYC) begin
                sw_cnt_r <= sw_cnt_r + 4'h1;
            end
        end
    end

    assign sys_clk_gate_fast_o = (sw_state_r == CS_FAST) & ~asleep_r;
    assign sys_clk_gate_slow_o = (sw_state_r == CS_SLOW) & ~asleep_r;
    assign sys_clk_from_slow_o = (sw_state_r == CS_SLOW) | (sw_state_r == CS_TO_SLOW);
    assign sys_clk_run_o = ~asleep_r;
    assign fast_rc_run_o = (osc_cfg_i == OSC_INT_RC | slow_pair) &
                           (sw_state_r != CS_SLOW) & ~asleep_r;
    assign slow_crystal_run_o = slow_pair;
    assign timers_run_o = slow_pair | ~asleep_r;
    assign fast_rc_freq_o = rc_freq_cfg_i;

    // Oscillator pin ownership per option.
    assign osc_pin_one_gpio_o = (osc_cfg_i == OSC_INT_RC);
    assign osc_pin_two_gpio_o = (osc_cfg_i == OSC_INT_RC) | (osc_cfg_i == OSC_EXT_RC);

    assign ext_irq_rise_en_o = system_control_b_r[EDGE_LSB];
    assign ext_irq_fall_en_o = system_control_b_r[EDGE_LSB+1];
    assign timebase_exp_o = 4'(TB_EXP_BASE) + {2'h0, system_control_b_r[TB_LSB+1:TB_LSB]};

    assign watchdog_en_o = wdt_option_on_i |
                           (system_control_b_r[WDT_LSB+3:WDT_LSB] != WDT_OFF_CODE);
    assign wdt_clk_sel_o = wdt_src_sel_i;
    assign tb_clk_sel_o = tb_src_sel_i;

    // Sleep state: entered on request, left on a selected falling edge.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_a_prev_r <= 8'hFF;
            asleep_r <= 1'b0;
            wake_o <= 1'b0;
        end else if (clk_en_i) begin
            port_a_prev_r <= port_a_in_i;
            wake_o <= asleep_r & |(port_a_prev_r & ~port_a_in_i & port_a_wake_select_r);
            if (asleep_r & |(port_a_prev_r & ~port_a_in_i & port_a_wake_select_r)) begin
                asleep_r <= 1'b0;
            end else if (sleep_req_i) begin
                asleep_r <= 1'b1;
            end
        end
    end

    assign port_a_pullhigh_o = port_a_pullhigh_select_r;
    assign port_b_pullhigh_o = port_b_pullhigh_select_r;
    assign port_c_pullhigh_o = port_c_pullhigh_select_r;
    assign port_d_pullhigh_o = port_d_pullhigh_select_r;
    assign lcd_common_line_o = lcd_common_line_control_r;

endmodule

/* File: core/sysctl_pkg.sv */
// Constants, register map and encodings for the system control register bank.
// Assumes an APB master with 32-bit data and one aligned word per register.
//
// Operation
// - Control A bits 7 to 4 read zero and ignore writes.
// - Divider enable: 00 none, 01 reserved, 10 true only, 11 both outputs.
// - A disabled divider output returns its pin to ordinary port use.
// - Slow crystal power bit: 0 quick start, 1 low power.
// - Clock mode 0 selects fast internal RC; 1 selects slow crystal, stops RC.
// - Clock mode acts only in fast internal RC plus slow crystal configuration.
// - Interrupt edge: 00 off, 01 rising, 10 falling, 11 both edges.
// - Time-base period codes 00 to 11 give 2^10 to 2^13 source periods.
// - Watchdog field 1010 requests off; any other value enables it.
// - Watchdog off only when option off and field holds 1010.
// - Wake select picks port A pins that wake on a falling edge.
// - Pull-high selects connect pull-ups to selected input pins, ports A to D.
// - Common-line control drives bias levels on port B low four pins.
// - Fast internal RC gives 4, 8 or 12 MHz chosen by option.
// - Fast internal RC frees both oscillator pins for port use.
// - External RC uses only the first oscillator pin; second stays port.
// - Slow crystal may pair only with the fast internal RC.
// - Sleep stops the system clock; slow crystal keeps timers running.
// - Oscillators are also selectable as watchdog and time-base clocks.
// - Power-on clears the slow crystal power bit.
package sysctl_pkg;

    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_A_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CTRL_B_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] WAKE_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] PU_A_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] PU_B_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] PU_C_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] PU_D_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] COM_OFS = 8'h1C;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h20;

    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h8A;
    localparam logic [7:0] PORT_SEL_RST = 8'h00;
    localparam logic [3:0] COM_RST = 4'h0;
    localparam logic [3:0] CTRL_A_MASK = 4'hF;

    localparam int CLKMODE_BIT = 0;
    localparam int LOWPWR_BIT = 1;
    localparam int DIVEN_LSB = 2;
    localparam int WDT_LSB = 0;
    localparam int TB_LSB = 4;
    localparam int EDGE_LSB = 6;

    localparam logic [1:0] DIV_OFF = 2'h0;
    localparam logic [1:0] DIV_TRUE = 2'h2;
    localparam logic [1:0] DIV_BOTH = 2'h3;
    localparam logic [3:0] WDT_OFF_CODE = 4'hA;
    localparam int TB_EXP_BASE = 10;

    // Oscillator configuration option codes.
    typedef enum logic [1:0] {
        OSC_FAST_XTAL = 2'h0,
        OSC_EXT_RC = 2'h1,
        OSC_INT_RC = 2'h2,
        OSC_INT_RC_SLOW_XTAL = 2'h3
    } osc_cfg_t;

    // Fast internal RC frequency option codes.
    typedef enum logic [1:0] {
        RC_4MHZ = 2'h0,
        RC_8MHZ = 2'h1,
        RC_12MHZ = 2'h2
    } rc_freq_t;

    // One-hot state of the glitch-free system clock switch.
    typedef enum logic [3:0] {
        CS_FAST = 4'h1,
        CS_TO_SLOW = 4'h2,
        CS_SLOW = 4'h4,
        CS_TO_FAST = 4'h8
    } clk_sw_t;

    localparam logic [3:0] SW_SETTLE_CYC = 4'h4;

endpackage

/* File: dv/sysctl_regs_checker.sv */
// Concurrent checks on the ports of the system control register bank.
// Assumes it is bound into the bank, which an APB master drives.
`timescale 1ns/1ps
module sysctl_regs_checker (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [sysctl_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pslverr_o,
    input wire sysctl_pkg::osc_cfg_t osc_cfg_i,
    input wire logic wdt_option_on_i,
    input wire logic divider_true_en_o,
    input wire logic divider_comp_en_o,
    input wire logic divider_pin_true_gpio_o,
    input wire logic divider_pin_comp_gpio_o,
    input wire logic slow_crystal_low_power_o,
    input wire logic fast_rc_run_o,
    input wire logic sys_clk_from_slow_o,
    input wire logic osc_pin_one_gpio_o,
    input wire logic osc_pin_two_gpio_o,
    input wire logic ext_irq_rise_en_o,
    input wire logic ext_irq_fall_en_o,
    input wire logic [3:0] timebase_exp_o,
    input wire logic watchdog_en_o,
    input wire logic wake_o
);
    import sysctl_pkg::*;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_wr_a;
        psel_i && penable_i && pwrite_i && clk_en_i && paddr_i == CTRL_A_OFS;
    endsequence
    sequence s_wr_b;
        psel_i && penable_i && pwrite_i && clk_en_i && paddr_i == CTRL_B_OFS;
    endsequence
    sequence s_to_slow;
        s_wr_a ##0 (pwdata_i[CLKMODE_BIT] && osc_cfg_i == OSC_INT_RC_SLOW_XTAL);
    endsequence
    property p_ctrl_a;
        s_wr_a |=> divider_true_en_o == $past(pwdata_i[3])
            && divider_comp_en_o == ($past(pwdata_i[3:2]) == DIV_BOTH)
            && slow_crystal_low_power_o == $past(pwdata_i[1]);
    endproperty
    a_ctrl_a: assert property (p_ctrl_a) else $error("control A not applied");
    property p_ctrl_b;
        s_wr_b |=> timebase_exp_o == 4'hA + {2'h0, $past(pwdata_i[5:4])}
            && ext_irq_rise_en_o == $past(pwdata_i[6]) && ext_irq_fall_en_o == $past(pwdata_i[7]);
    endproperty
    a_ctrl_b: assert property (p_ctrl_b) else $error("control B not applied");
    property p_wdt;
        s_wr_b |=> watchdog_en_o == (wdt_option_on_i || $past(pwdata_i[3:0]) != WDT_OFF_CODE);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog enable wrong");
    property p_gpio;
        divider_pin_true_gpio_o != divider_true_en_o && divider_pin_comp_gpio_o != divider_comp_en_o;
    endproperty
    a_gpio: assert property (p_gpio) else $error("divider pin function wrong");
    property p_int_rc;
        osc_cfg_i == OSC_INT_RC |-> osc_pin_one_gpio_o && osc_pin_two_gpio_o;
    endproperty
    a_int_rc: assert property (p_int_rc) else $error("oscillator pins not freed");
    property p_ext_rc;
        osc_cfg_i == OSC_EXT_RC |-> !osc_pin_one_gpio_o && osc_pin_two_gpio_o;
    endproperty
    a_ext_rc: assert property (p_ext_rc) else $error("external RC pin use wrong");
    property p_mode_only;
        osc_cfg_i != OSC_INT_RC_SLOW_XTAL |-> !sys_clk_from_slow_o;
    endproperty
    a_mode_only: assert property (p_mode_only) else $error("slow clock in wrong config");
    property p_to_slow;
        s_to_slow |-> ##[1:12] (sys_clk_from_slow_o && !fast_rc_run_o);
    endproperty
    a_to_slow: assert property (p_to_slow) else $error("no switch to slow clock");
    property p_wake;
        $rose(wake_o) |=> !wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse too long");
    property p_slverr;
        psel_i && penable_i && paddr_i > STATUS_OFS |-> pslverr_o;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");
endmodule

bind sysctl_regs sysctl_regs_checker sysctl_regs_checker_inst (.*);

/* File: dv/testbench.sv */
// Self-checking bench for the system control register bank.
// Assumes the checker binds itself to the bank.
`timescale 1ns/1ps
module testbench;
    import sysctl_pkg::*;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, sleep_req_i = 1'b0;
    logic wdt_option_on_i = 1'b0;
    logic [7:0] paddr_i = 8'h00, port_a_in_i = 8'hFF;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    osc_cfg_t osc_cfg_i = OSC_INT_RC;
    rc_freq_t rc_freq_cfg_i = RC_4MHZ;
    logic [1:0] wdt_src_sel_i = 2'h0, tb_src_sel_i = 2'h0;
    logic pready_o, pslverr_o, divider_true_en_o, divider_comp_en_o, divider_pin_true_gpio_o;
    logic divider_pin_comp_gpio_o, slow_crystal_low_power_o, fast_rc_run_o, slow_crystal_run_o;
    logic sys_clk_from_slow_o, sys_clk_gate_fast_o, sys_clk_gate_slow_o, sys_clk_run_o;
    logic timers_run_o, osc_pin_one_gpio_o, osc_pin_two_gpio_o, config_error_o, wake_o;
    logic ext_irq_rise_en_o, ext_irq_fall_en_o, watchdog_en_o;
    logic [1:0] fast_rc_freq_o, wdt_clk_sel_o, tb_clk_sel_o;
    logic [3:0] timebase_exp_o, lcd_common_line_o;
    logic [7:0] port_a_pullhigh_o, port_b_pullhigh_o, port_c_pullhigh_o, port_d_pullhigh_o;
    logic [3:0] wv [4] = '{4'hA, 4'h5, 4'hB, 4'h0};
    int miscompares = 0;
    int n_checks = 0;

    sysctl_regs sysctl_regs_inst (.*);

    always #12.5 clock_i = ~clock_i;

    task automatic results();
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The request opens with the setup cycle and holds until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge clock_i);
        paddr_i <= a;
        pwrite_i <= wr;
        pwdata_i <= d;
        psel_i <= 1'b1;
        @(posedge clock_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clock_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            results();
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        @(negedge clock_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk(e, err);
    endtask

    task automatic wait_src(input logic want);
        int k;
        k = 0;
        while ((want ? sys_clk_gate_slow_o : sys_clk_gate_fast_o) !== 1'b1 && k < 30) begin
            @(posedge clock_i);
            k++;
        end
        if (k >= 30) begin
            miscompares++;
            results();
        end
        @(negedge clock_i);
    endtask

    task automatic count_wake(output int w);
        w = 0;
        repeat (8) begin
            @(negedge clock_i);
            w = w + int'(wake_o === 1'b1);
        end
    endtask

    initial begin
        int w;
        repeat (3) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(negedge clock_i);
        chk(slow_crystal_low_power_o, 0);
        rd(CTRL_A_OFS, 32'h00, 1'b0);
        rd(CTRL_B_OFS, 32'h8A, 1'b0);
        wr(CTRL_A_OFS, 32'hFF);
        rd(CTRL_A_OFS, 32'h0F, 1'b0);
        chk(sys_clk_from_slow_o, 0);
        for (int c = 0; c < 4; c++) begin
            wr(CTRL_A_OFS, c * 4 + (c % 2) * 2);
            chk({divider_true_en_o, divider_comp_en_o}, (c >> 1) * 2 + (c == 3));
            chk({divider_pin_true_gpio_o, divider_pin_comp_gpio_o}, (c < 2) * 2 + (c != 3));
            chk(slow_crystal_low_power_o, c % 2);
        end
        $display("test control A done");
        for (int c = 0; c < 4; c++) begin
            wr(CTRL_B_OFS, c * 8'h50 + 5);
            chk({ext_irq_fall_en_o, ext_irq_rise_en_o}, c);
            chk(timebase_exp_o, 10 + c);
            rd(CTRL_B_OFS, c * 8'h50 + 5, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_i);
            wdt_option_on_i <= (i >= 4);
            wr(CTRL_B_OFS, wv[i % 4]);
            chk(watchdog_en_o, i >= 4 || wv[i % 4] != 4'hA);
        end
        @(posedge clock_i);
        clk_en_i <= 1'b0;
        wr(CTRL_B_OFS, 32'h5A);
        @(posedge clock_i);
        clk_en_i <= 1'b1;
        rd(CTRL_B_OFS, 32'h00, 1'b0);
        $display("test control B done");
        @(posedge clock_i);
        osc_cfg_i <= OSC_INT_RC_SLOW_XTAL;
        wr(CTRL_A_OFS, 32'h01);
        wait_src(1'b1);
        chk({fast_rc_run_o, slow_crystal_run_o}, 1);
        chk(sys_clk_from_slow_o, 1);
        rd(STATUS_OFS, 32'h04, 1'b0);
        wr(CTRL_A_OFS, 32'h00);
        wait_src(1'b0);
        chk(fast_rc_run_o, 1);
        for (int c = 0; c < 4; c++) begin
            @(posedge clock_i);
            osc_cfg_i <= osc_cfg_t'(c);
            rc_freq_cfg_i <= rc_freq_t'(c % 3);
            wdt_src_sel_i <= 2'(c);
            tb_src_sel_i <= 2'(3 - c);
            @(negedge clock_i);
            chk(osc_pin_one_gpio_o, c == 2);
            chk(osc_pin_two_gpio_o, c == 1 || c == 2);
            chk(config_error_o, 0);
            chk(fast_rc_freq_o, c % 3);
            chk({wdt_clk_sel_o, tb_clk_sel_o}, c * 4 + 3 - c);
        end
        $display("test oscillator done");
        for (int i = 0; i < 6; i++)
            wr(WAKE_OFS + 8'(4 * i), (i == 5) ? 6 : 17 * (i + 1));
        chk({port_a_pullhigh_o, port_b_pullhigh_o, port_c_pullhigh_o, port_d_pullhigh_o},
            32'h22334455);
        chk(lcd_common_line_o, 6);
        rd(PU_C_OFS, 32'h44, 1'b0);
        wr(8'h40, 32'h5A);
        rd(8'h40, 32'h0, 1'b1);
        $display("test port registers done");
        @(posedge clock_i);
        osc_cfg_i <= OSC_INT_RC_SLOW_XTAL;
        sleep_req_i <= 1'b1;
        @(posedge clock_i);
        sleep_req_i <= 1'b0;
        @(negedge clock_i);
        chk({sys_clk_run_o, timers_run_o}, 1);
        @(posedge clock_i);
        port_a_in_i <= 8'hFD;
        count_wake(w);
        chk(w, 0);
        @(posedge clock_i);
        port_a_in_i <= 8'hFC;
        count_wake(w);
        chk(w, 1);
        $display("test sleep and wake done");
        results();
    end
endmodule
